// ==== hdl/ssm_params.svh ====
// constants for the serial sram multi lane port
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

`define SSM_CMD_WRMODE     8'h01
`define SSM_CMD_WRITE      8'h02
`define SSM_CMD_READ       8'h03
`define SSM_CMD_RDMODE     8'h05
`define SSM_CMD_ENTER_QUAD 8'h38
`define SSM_CMD_ENTER_DUAL 8'h3b
`define SSM_CMD_EXIT_MULTI 8'hff

`define SSM_MODE_BYTE      2'h0
`define SSM_MODE_PAGE      2'h2
`define SSM_MODE_SEQ       2'h1
`define SSM_MODE_RESET     2'h1
`define SSM_MODE_HI        7
`define SSM_MODE_LO        6
`define SSM_MODE_RSVD      6'h00

`define SSM_DUMMY_SINGLE   4'h8
`define SSM_DUMMY_DUAL     4'h4
`define SSM_DUMMY_QUAD     4'h2

`define SSM_ADDR_W         17
`define SSM_MEM_DEPTH      131072
`define SSM_PAGE_BITS      5
`define SSM_CMD_BITS       5'h08
`define SSM_ADDR_BITS      5'h18
`define SSM_BYTE_BITS      5'h08

`endif

// ==== hdl/ssm_pkg.sv ====
// types shared by the serial sram multi lane port
package ssm_pkg;

  // lane width of the link
  typedef enum logic [1:0] {
    LANE_SINGLE,
    LANE_DUAL,
    LANE_QUAD
  } ssm_lane_type;

  // transfer sequence states
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_RDATA,
    ST_WDATA,
    ST_MRREAD,
    ST_MRWRITE,
    ST_DONE
  } ssm_state_type;

  // pin levels as seen from outside
  typedef struct packed {
    logic       select_n;
    logic       sclk;
    logic [3:0] lane;
  } ssm_pins_type;

endpackage

// ==== hdl/ssm_port.sv ====
// serial sram command and data port with single, dual and quad lanes
`timescale 1ns/10ps
`default_nettype none
`include "ssm_params.svh"

// Notes on behaviour
// - select high means standby: all lane outputs released.
// - inputs taken on serial clock rise, outputs changed after its fall.
// - pause freezes the sequence while selected; it resumes where it stopped.
// - pause change applies at once with clock low, else at next fall.
// - while paused, clock and data lanes are ignored.
// - output enable drops and returns at once with the pause pin.
// - no pause in quad mode; that pin is lane three.
// - dual mode uses lanes zero and one both ways.
// - spare pin unused except as lane two in quad mode.
// - each operation opens with an eight bit instruction.
// - everything moves most significant bit first.
// - mode bits 7:6: 00 byte, 10 page, 01 sequential.
// - byte mode moves one data byte after the address.
// - page mode wraps within 32 byte page.
// - sequential mode wraps from top of array to zero.
// - write: instruction, 24 bit address, data until select rises.
// - read waits 8, 4 or 2 dummy clocks by lane width.
// - read advances address per byte until select rises.
// - code 03 is array read.
// - code 02 is array write.
// - code 05 reads mode register, code 01 writes it.
// - mode bits 5:0 are kept as zero.
// - mode register resets to sequential.
// - codes 3b, 38 enter dual, quad; ff returns to single.
module ssm_port (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 select_n_in,
  input  wire logic                 sclk_in,
  input  wire logic [3:0]           lane_in,
  output logic      [3:0]           lane_out,
  output logic      [3:0]           lane_oe_out,
  output var ssm_pkg::ssm_lane_type lane_mode_out,
  output logic      [1:0]           addr_mode_out,
  output logic                      paused_out
);
  import ssm_pkg::*;

  // bits moved per serial clock
  function automatic logic [4:0] lane_width(input ssm_lane_type m);
    case (m)
      LANE_DUAL: lane_width = 5'h02;
      LANE_QUAD: lane_width = 5'h04;
      default:   lane_width = 5'h01;
    endcase
  endfunction

  // shift the sampled lanes in, high lane carries the higher bit
  function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [3:0] ln,
                                           input ssm_lane_type m);
    case (m)
      LANE_DUAL: shift_in = {sr[21:0], ln[1:0]};
      LANE_QUAD: shift_in = {sr[19:0], ln};
      default:   shift_in = {sr[22:0], ln[0]};
    endcase
  endfunction

  // next array address for the addressing mode
  function automatic logic [16:0] next_addr(input logic [16:0] a, input logic [1:0] md);
    if (md == `SSM_MODE_PAGE) begin
      next_addr = {a[16:`SSM_PAGE_BITS], a[4:0] + 5'h01};
    end else begin
      next_addr = a + 17'h00001;
    end
  endfunction

  ssm_pins_type  pins_raw;
  ssm_pins_type  pins_s;
  ssm_state_type state_r,     state_nxt;
  ssm_lane_type  lane_mode_r, lane_mode_nxt;
  logic [1:0]    mode_r,      mode_nxt;
  logic [23:0]   in_sr_r,     in_sr_nxt;
  logic [4:0]    bit_cnt_r,   bit_cnt_nxt;
  logic [4:0]    out_cnt_r,   out_cnt_nxt;
  logic [7:0]    out_sr_r,    out_sr_nxt;
  logic [3:0]    dummy_cnt_r, dummy_cnt_nxt;
  logic [16:0]   addr_r,      addr_nxt;
  logic          is_write_r,  is_write_nxt;
  logic          last_r,      last_nxt;
  logic          drive_r,     drive_nxt;
  logic [3:0]    lane_r,      lane_nxt;
  logic          paused_r,    paused_nxt;
  logic          sclk_d_r;
  logic          wr_en;
  logic [7:0]    wr_data;
  logic [7:0]    mem_r [0:`SSM_MEM_DEPTH-1];

  assign pins_raw = '{select_n: select_n_in, sclk: sclk_in, lane: lane_in};

  ssm_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .raw_in     (pins_raw),
    .sync_out   (pins_s)
  );

  // edge and pause decode from the synchronised pins
  wire        selected   = ~pins_s.select_n;
  wire        sclk_rise  = pins_s.sclk & ~sclk_d_r;
  wire        sclk_fall  = ~pins_s.sclk & sclk_d_r;
  wire        quad_mode  = (lane_mode_r == LANE_QUAD);
  wire        hold_pin   = ~quad_mode & ~pins_s.lane[3];
  wire        hold_req   = selected & hold_pin;
  wire        hold_apply = ~pins_s.sclk | sclk_fall;
  wire        act_rise   = selected & sclk_rise & ~paused_nxt;
  wire        act_fall   = selected & sclk_fall & ~paused_nxt;
  wire [4:0]  width      = lane_width(lane_mode_r);
  wire [4:0]  in_sum     = bit_cnt_r + width;
  wire [4:0]  out_sum    = out_cnt_r + width;
  wire [23:0] in_shift   = shift_in(in_sr_r, pins_s.lane, lane_mode_r);
  wire [7:0]  rd_byte    = mem_r[addr_r];
  wire [7:0]  mode_byte  = {mode_r, `SSM_MODE_RSVD};
  wire [7:0]  fresh_byte = (state_r == ST_MRREAD) ? mode_byte : rd_byte;
  wire [7:0]  emit_byte  = (out_cnt_r == 5'h00) ? fresh_byte : out_sr_r;
  wire        byte_mode  = (mode_r == `SSM_MODE_BYTE);

  // dummy clocks needed before read data
  wire [3:0]  dummy_need = (lane_mode_r == LANE_QUAD) ? `SSM_DUMMY_QUAD :
                           (lane_mode_r == LANE_DUAL) ? `SSM_DUMMY_DUAL :
                           `SSM_DUMMY_SINGLE;

  // output lanes for the current chunk, high bits first
  wire [3:0]  emit_lanes = (lane_mode_r == LANE_QUAD) ? emit_byte[7:4] :
                           (lane_mode_r == LANE_DUAL) ? {2'h0, emit_byte[7:6]} :
                           {2'h0, emit_byte[7], 1'b0};
  wire [7:0]  emit_rest  = emit_byte << width;

  // lanes driven per width; lane two only in quad mode
  wire [3:0]  lane_mask  = (lane_mode_nxt == LANE_QUAD) ? 4'hf :
                           (lane_mode_nxt == LANE_DUAL) ? 4'h3 : 4'h2;
  wire        hold_gate  = (lane_mode_nxt != LANE_QUAD) & ~pins_s.lane[3];
  wire [3:0]  oe_nxt     = (drive_nxt & selected & ~hold_gate) ? lane_mask : 4'h0;

  // pause tracking
  always_comb begin
    paused_nxt = paused_r;
    if (!selected) begin
      paused_nxt = 1'b0;
    end else if ((hold_req != paused_r) && hold_apply) begin
      paused_nxt = hold_req;
    end
  end

  // sequence state machine
  always_comb begin
    state_nxt     = state_r;
    lane_mode_nxt = lane_mode_r;
    mode_nxt      = mode_r;
    in_sr_nxt     = in_sr_r;
    bit_cnt_nxt   = bit_cnt_r;
    out_cnt_nxt   = out_cnt_r;
    out_sr_nxt    = out_sr_r;
    dummy_cnt_nxt = dummy_cnt_r;
    addr_nxt      = addr_r;
    is_write_nxt  = is_write_r;
    last_nxt      = last_r;
    drive_nxt     = drive_r;
    lane_nxt      = lane_r;
    wr_en         = 1'b0;
    wr_data       = in_shift[7:0];
    if (!selected) begin
      state_nxt   = ST_CMD;
      bit_cnt_nxt = 5'h00;
      out_cnt_nxt = 5'h00;
      drive_nxt   = 1'b0;
      last_nxt    = 1'b0;
    end else if (act_rise) begin
      in_sr_nxt   = in_shift;
      bit_cnt_nxt = in_sum;
      case (state_r)
        ST_CMD: begin
          if (in_sum == `SSM_CMD_BITS) begin
            bit_cnt_nxt = 5'h00;
            state_nxt   = ST_DONE;
            if (in_shift[7:0] == `SSM_CMD_READ) begin
              state_nxt    = ST_ADDR;
              is_write_nxt = 1'b0;
            end else if (in_shift[7:0] == `SSM_CMD_WRITE) begin
              state_nxt    = ST_ADDR;
              is_write_nxt = 1'b1;
            end else if (in_shift[7:0] == `SSM_CMD_RDMODE) begin
              state_nxt = ST_MRREAD;
            end else if (in_shift[7:0] == `SSM_CMD_WRMODE) begin
              state_nxt = ST_MRWRITE;
            end else if (in_shift[7:0] == `SSM_CMD_ENTER_DUAL) begin
              lane_mode_nxt = LANE_DUAL;
            end else if (in_shift[7:0] == `SSM_CMD_ENTER_QUAD) begin
              lane_mode_nxt = LANE_QUAD;
            end else if (in_shift[7:0] == `SSM_CMD_EXIT_MULTI) begin
              lane_mode_nxt = LANE_SINGLE;
            end
          end
        end
        ST_ADDR: begin
          if (in_sum == `SSM_ADDR_BITS) begin
            bit_cnt_nxt   = 5'h00;
            addr_nxt      = in_shift[16:0];
            dummy_cnt_nxt = 4'h0;
            state_nxt     = is_write_r ? ST_WDATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          dummy_cnt_nxt = dummy_cnt_r + 4'h1;
          if (dummy_cnt_nxt == dummy_need) begin
            state_nxt   = ST_RDATA;
            out_cnt_nxt = 5'h00;
          end
        end
        ST_WDATA: begin
          if (in_sum == `SSM_BYTE_BITS) begin
            bit_cnt_nxt = 5'h00;
            wr_en       = 1'b1;
            addr_nxt    = next_addr(addr_r, mode_r);
            if (byte_mode) begin
              state_nxt = ST_DONE;
            end
          end
        end
        ST_MRWRITE: begin
          if (in_sum == `SSM_BYTE_BITS) begin
            mode_nxt  = in_shift[`SSM_MODE_HI:`SSM_MODE_LO];
            state_nxt = ST_DONE;
          end
        end
        default: begin
          bit_cnt_nxt = bit_cnt_r;
        end
      endcase
    end else if (act_fall) begin
      if ((state_r == ST_RDATA) || (state_r == ST_MRREAD)) begin
        if (last_r && (out_cnt_r == 5'h00)) begin
          state_nxt = ST_DONE;
          drive_nxt = 1'b0;
        end else begin
          lane_nxt    = emit_lanes;
          out_sr_nxt  = emit_rest;
          drive_nxt   = 1'b1;
          out_cnt_nxt = out_sum;
          if (out_sum == `SSM_BYTE_BITS) begin
            out_cnt_nxt = 5'h00;
            if (state_r == ST_RDATA) begin
              addr_nxt = next_addr(addr_r, mode_r);
              last_nxt = byte_mode;
            end
          end
        end
      end else begin
        drive_nxt = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_r     <= ST_CMD;
      lane_mode_r <= LANE_SINGLE;
      mode_r      <= `SSM_MODE_RESET;
      in_sr_r     <= 24'h000000;
      bit_cnt_r   <= 5'h00;
      out_cnt_r   <= 5'h00;
      out_sr_r    <= 8'h00;
      dummy_cnt_r <= 4'h0;
      addr_r      <= 17'h00000;
      is_write_r  <= 1'b0;
      last_r      <= 1'b0;
      drive_r     <= 1'b0;
      lane_r      <= 4'h0;
      paused_r    <= 1'b0;
      sclk_d_r    <= 1'b0;
      lane_oe_out <= 4'h0;
    end else begin
      state_r     <= state_nxt;
      lane_mode_r <= lane_mode_nxt;
      mode_r      <= mode_nxt;
      in_sr_r     <= in_sr_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      out_cnt_r   <= out_cnt_nxt;
      out_sr_r    <= out_sr_nxt;
      dummy_cnt_r <= dummy_cnt_nxt;
      addr_r      <= addr_nxt;
      is_write_r  <= is_write_nxt;
      last_r      <= last_nxt;
      drive_r     <= drive_nxt;
      lane_r      <= lane_nxt;
      paused_r    <= paused_nxt;
      sclk_d_r    <= pins_s.sclk;
      lane_oe_out <= oe_nxt;
    end
  end

  // array storage, written at the byte address before it advances
  always_ff @(posedge sys_clk_in) begin
    if (wr_en) begin
      mem_r[addr_r] <= wr_data;
    end
  end

  // status outputs mirror registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lane_out      <= 4'h0;
      lane_mode_out <= LANE_SINGLE;
      addr_mode_out <= `SSM_MODE_RESET;
      paused_out    <= 1'b0;
    end else begin
      lane_out      <= lane_nxt;
      lane_mode_out <= lane_mode_nxt;
      addr_mode_out <= mode_nxt;
      paused_out    <= paused_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/ssm_sync.sv ====
// two flop synchroniser for the link pins
`timescale 1ns/10ps
`default_nettype none

module ssm_sync (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire ssm_pkg::ssm_pins_type raw_in,
  output var  ssm_pkg::ssm_pins_type sync_out
);
  import ssm_pkg::*;

  ssm_pins_type meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      meta_r   <= '{select_n: 1'b1, sclk: 1'b0, lane: 4'hf};
      sync_out <= '{select_n: 1'b1, sclk: 1'b0, lane: 4'hf};
    end else begin
      meta_r   <= raw_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ==== verification/ssm_mst.sv ====
// behavioural bus master driving the serial sram port
`timescale 1ns/10ps
`default_nettype none
module ssm_mst (
  output logic            select_n_out,
  output logic            sclk_out,
  output logic [3:0]      drv_out,
  output logic [3:0]      en_out,
  input  wire logic [3:0] pin_in
);
  int w = 1; // lanes per clock
  // idle: deselected, clock low, lanes released
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    drv_out = 4'h0;
    en_out = 4'h0;
  end
  // select change, then a quiet gap
  task automatic sel(input bit s);
    select_n_out = s;
    #400;
  endtask
  // pause pin low while clock low; released it is pulled high
  task automatic hold_pin(input bit on);
    drv_out[3] = 1'b0;
    en_out[3] = on;
  endtask
  // n bits msb first, w per clock; drive with clock low, sample before the rise
  task automatic xfer(input logic [31:0] tx, input int n, input bit rd, output logic [31:0] rx);
    logic [31:0] sh;
    sh = tx << (32 - n);
    rx = 32'h0;
    for (int i = 0; i < n; i += w) begin
      sclk_out = 1'b0;
      en_out = rd ? 4'h0 : (w == 4 ? 4'hf : w == 2 ? 4'h3 : 4'h1);
      drv_out = w == 4 ? sh[31:28] : w == 2 ? {2'h0, sh[31:30]} : {3'h0, sh[31]};
      sh = sh << w;
      #80;
      rx = (rx << w) | {28'h0, w == 4 ? pin_in : w == 2 ? {2'h0, pin_in[1:0]} :
                        {3'h0, pin_in[1]}};
      sclk_out = 1'b1;
      #80;
    end
    sclk_out = 1'b0;
    en_out = 4'h0;
  endtask
  // bare clock pulses, lanes left as they stand
  task automatic pulse(input int n);
    repeat (n) begin
      sclk_out = 1'b1;
      #80;
      sclk_out = 1'b0;
      #80;
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/ssm_port_asserts.sv ====
// concurrent checks on the serial sram port pins
`timescale 1ns/10ps
`default_nettype none
module ssm_port_asserts (
  input wire logic                  sys_clk_in,
  input wire logic                  reset_in,
  input wire logic                  select_n_in,
  input wire logic                  sclk_in,
  input wire logic [3:0]            lane_in,
  input wire logic [3:0]            lane_out,
  input wire logic [3:0]            lane_oe_out,
  input wire ssm_pkg::ssm_lane_type lane_mode_out,
  input wire logic [1:0]            addr_mode_out,
  input wire logic                  paused_out
);
  import ssm_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // select or pause pin held long enough to pass the synchroniser
  sequence s_deselect; select_n_in [*6]; endsequence
  sequence s_pause_held; (!lane_in[3] && lane_mode_out != LANE_QUAD) [*6]; endsequence
  property p_standby; s_deselect |-> lane_oe_out == 4'h0; endproperty
  a_standby: assert property (p_standby) else $error("driven while deselected");
  property p_pause_off; s_pause_held |-> !lane_oe_out[1]; endproperty
  a_pause_off: assert property (p_pause_off) else $error("driven while paused");
  property p_quad_free; lane_mode_out == LANE_QUAD |-> !paused_out; endproperty
  a_quad_free: assert property (p_quad_free) else $error("paused in quad");
  property p_mode_rst;
    $fell(reset_in) |-> addr_mode_out == 2'h1 && lane_mode_out == LANE_SINGLE;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("bad reset mode");
  property p_oe_set;
    lane_oe_out != 4'h0 |-> lane_oe_out == (lane_mode_out == LANE_QUAD ? 4'hf :
                                            lane_mode_out == LANE_DUAL ? 4'h3 : 4'h2);
  endproperty
  a_oe_set: assert property (p_oe_set) else $error("wrong lanes enabled");
  property p_frozen; paused_out && $past(paused_out) |-> $stable(lane_out); endproperty
  a_frozen: assert property (p_frozen) else $error("output moved while paused");
  property p_pause_src;
    $rose(paused_out) |-> !lane_in[3] && lane_mode_out != LANE_QUAD;
  endproperty
  a_pause_src: assert property (p_pause_src) else $error("pause without pin");
  property p_mode_sel; !$stable(addr_mode_out) |-> !$past(select_n_in, 5); endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode changed unselected");
endmodule

bind ssm_port ssm_port_asserts ssm_port_asserts_i (
  .sys_clk_in    (sys_clk_in),
  .reset_in      (reset_in),
  .select_n_in   (select_n_in),
  .sclk_in       (sclk_in),
  .lane_in       (lane_in),
  .lane_out      (lane_out),
  .lane_oe_out   (lane_oe_out),
  .lane_mode_out (lane_mode_out),
  .addr_mode_out (addr_mode_out),
  .paused_out    (paused_out)
);
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the serial sram port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ssm_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         reset_in = 1'b1;
  logic         select_n_in, sclk_in, paused_out;
  logic [3:0]   drv, en, lane_in, lane_out, lane_oe_out;
  logic [1:0]   addr_mode_out;
  ssm_lane_type lane_mode_out;
  logic [31:0]  r, r2;
  int           fail_count = 0;
  int           num_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  // wire level: device, then master, else pull-up
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lane_in[k] = lane_oe_out[k] ? lane_out[k] : en[k] ? drv[k] : 1'b1;
    end
  end
  ssm_port ssm_port_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .select_n_in(select_n_in),
    .sclk_in(sclk_in), .lane_in(lane_in), .lane_out(lane_out), .lane_oe_out(lane_oe_out),
    .lane_mode_out(lane_mode_out), .addr_mode_out(addr_mode_out), .paused_out(paused_out));
  ssm_mst ssm_mst_i (.select_n_out(select_n_in), .sclk_out(sclk_in), .drv_out(drv), .en_out(en),
    .pin_in(lane_in));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one command: instruction, address, write bits, dummy and read bits
  task automatic txn(input logic [7:0] c, input logic [23:0] a, input bit ha,
                     input logic [31:0] wd, input int nw, input int nr, output logic [31:0] rd);
    logic [31:0] x;
    rd = 32'h0;
    ssm_mst_i.sel(1'b0);
    ssm_mst_i.xfer({24'h0, c}, 8, 1'b0, x);
    if (ha) ssm_mst_i.xfer({8'h0, a}, 24, 1'b0, x);
    if (nw > 0) ssm_mst_i.xfer(wd, nw, 1'b0, x);
    if (nr > 0 && ha) ssm_mst_i.xfer(32'h0, 8, 1'b0, x);
    if (nr > 0) ssm_mst_i.xfer(32'h0, nr, 1'b1, rd);
    ssm_mst_i.sel(1'b1);
  endtask
  task automatic setm(input logic [1:0] m);
    txn(8'h01, 24'h0, 1'b0, {24'h0, m, 6'h00}, 8, 0, r);
  endtask
  // partial instruction aborted, then every addressing mode written and read back
  task automatic t_modes;
    logic [1:0] ml[3] = '{2'h0, 2'h2, 2'h1};
    chk(32'(addr_mode_out), 32'h1);
    chk(32'(lane_mode_out), 32'(LANE_SINGLE));
    ssm_mst_i.sel(1'b0);
    ssm_mst_i.xfer(32'hf, 4, 1'b0, r);
    ssm_mst_i.sel(1'b1);
    foreach (ml[i]) begin
      setm(ml[i]);
      chk(32'(addr_mode_out), 32'(ml[i]));
      txn(8'h05, 24'h0, 1'b0, 32'h0, 0, 8, r);
      chk(r, {24'h0, ml[i], 6'h00});
    end
  endtask
  // sequential wrap at the array top, ignored high address bits
  task automatic t_seq;
    txn(8'h02, 24'hff_ffff, 1'b1, 32'ha55a, 16, 0, r);
    txn(8'h03, 24'h01_ffff, 1'b1, 32'h0, 0, 16, r);
    chk(r, 32'ha55a);
  endtask
  // page wrap on write and read
  task automatic t_page;
    setm(2'h2);
    txn(8'h02, 24'h00_001e, 1'b1, 32'h112233, 24, 0, r);
    txn(8'h03, 24'h00_0000, 1'b1, 32'h0, 0, 8, r);
    chk(r, 32'h33);
    txn(8'h03, 24'h00_001e, 1'b1, 32'h0, 0, 24, r);
    chk(r, 32'h112233);
  endtask
  // byte mode stores and returns one byte only
  task automatic t_byte;
    setm(2'h0);
    txn(8'h02, 24'h00_0040, 1'b1, 32'h3344, 16, 0, r);
    txn(8'h03, 24'h00_0040, 1'b1, 32'h0, 0, 16, r);
    chk(r, 32'h33ff);
    setm(2'h1);
  endtask
  // dual then quad: enter, write, read with shorter latency, exit
  task automatic t_lanes;
    for (int w = 2; w <= 4; w += 2) begin
      txn(w == 2 ? 8'h3b : 8'h38, 24'h0, 1'b0, 32'h0, 0, 0, r);
      ssm_mst_i.w = w;
      chk(32'(lane_mode_out), w == 2 ? 32'(LANE_DUAL) : 32'(LANE_QUAD));
      txn(8'h02, 24'h00_0100, 1'b1, 32'h0c3a ^ w, 16, 0, r);
      txn(8'h03, 24'h00_0100, 1'b1, 32'h0, 0, 16, r);
      chk(r, 32'h0c3a ^ w);
      ssm_mst_i.sel(1'b0);
      ssm_mst_i.hold_pin(1'b1);
      #200;
      chk(32'(paused_out), w == 2 ? 32'h1 : 32'h0);
      ssm_mst_i.hold_pin(1'b0);
      ssm_mst_i.sel(1'b1);
      txn(8'hff, 24'h0, 1'b0, 32'h0, 0, 0, r);
      ssm_mst_i.w = 1;
      chk(32'(lane_mode_out), 32'(LANE_SINGLE));
    end
  endtask
  // pause in mid-read, clocks ignored, resume where it stopped
  task automatic t_pause;
    ssm_mst_i.sel(1'b0);
    ssm_mst_i.xfer(32'h03, 8, 1'b0, r);
    ssm_mst_i.xfer(32'h1f, 24, 1'b0, r);
    ssm_mst_i.xfer(32'h0, 8, 1'b0, r);
    ssm_mst_i.xfer(32'h0, 4, 1'b1, r);
    #60;
    ssm_mst_i.hold_pin(1'b1);
    #200;
    chk({31'h0, lane_oe_out[1]}, 32'h0);
    ssm_mst_i.pulse(2);
    chk(32'(paused_out), 32'h1);
    ssm_mst_i.hold_pin(1'b0);
    #200;
    chk({31'h0, lane_oe_out[1]}, 32'h1);
    ssm_mst_i.xfer(32'h0, 4, 1'b1, r2);
    ssm_mst_i.sel(1'b1);
    chk({24'h0, r[3:0], r2[3:0]}, 32'h22);
    chk(32'(lane_oe_out), 32'h0);
  endtask
  // reset, first selection, then the scenarios
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    ssm_mst_i.sel(1'b0);
    ssm_mst_i.sel(1'b1);
    t_modes;
    t_seq;
    t_page;
    t_byte;
    t_lanes;
    t_pause;
    tally_and_finish;
  end
  // watchdog
  initial begin
    #900000;
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
